// *** design/rip_pkg.sv ***
// constants and carrier types for the radio instruction and status port
package rip_pkg;

    // register selected by one cpu access; writes and reads follow from the register
    typedef enum logic [2:0] {
        RIP_INSTR_B,
        RIP_INSTR_W,
        RIP_DIN_B,
        RIP_DIN_W,
        RIP_DOUT_B,
        RIP_DOUT_W,
        RIP_STAT_B,
        RIP_STAT_W
    } rip_sel_e;

    typedef struct packed {
        rip_sel_e    sel;
        logic [15:0] wdata;
    } rip_acc_s;

    // one byte towards the radio core
    typedef struct packed {
        logic       is_instr;
        logic [7:0] data;
    } rip_link_s;

    // one byte back from the radio core
    typedef struct packed {
        logic       is_status;
        logic [7:0] data;
    } rip_ret_s;

    localparam int unsigned RIP_STALL_MAX   = 16;
    localparam int unsigned RIP_BUF_DEPTH   = 2;
    localparam int unsigned RIP_DOUT_DEPTH  = 2;
    localparam int unsigned RIP_BURST_BIT   = 6;
    localparam logic [5:0]  RIP_ADDR_MASK   = 6'h3f;
    localparam logic [5:0]  RIP_STROBE_LO   = 6'h30;
    localparam logic [5:0]  RIP_STROBE_HI   = 6'h3d;
    localparam logic [7:0]  RIP_RESET_STROBE = 8'h30;
    localparam logic [7:0]  RIP_NOP_STROBE  = 8'h3d;
    localparam logic [1:0]  RIP_LEN_STROBE  = 2'h0;
    localparam logic [1:0]  RIP_LEN_SINGLE  = 2'h1;
    localparam logic [7:0]  RIP_STAT_RESET  = 8'h00;
    localparam logic [7:0]  RIP_DOUT_RESET  = 8'h00;

endpackage : rip_pkg

// *** design/rip_port.sv ***
// instruction, operand, data-out and status port in front of the radio core
//
// How it works
// RL1: every forwarded instruction except the core reset strobe earns a status byte back.
// RL2: each operand byte sent to the core earns one returned data byte.
// RL3: byte and word instruction, data-in, data-out and status registers carry all traffic.
// RL4: word instruction write sends instruction then first operand; others via data-in.
// RL5: software uses the byte instruction register for strobes or separately fed operands.
// RL6: status byte refreshes on every status return from the core and reads through byte status.
// RL7: word status read returns latest status with first returned data byte.
// RL8: word status read after a byte instruction sets the output error flag.
// RL9: no-op strobe is forwarded only to fetch a fresh status.
// RL10: core reset strobe resets port (all but its error flags) and core and yields no status.
// RL11: instruction ends when its operands are complete or a new one arrives.
// RL12: new instruction other than the core reset strobe before finite operands complete sets the operand error flag.
// RL13: erroneous access stalls up to 16 cycles, then completes and flags the error.
// RL14: surplus operands set the operand error flag and are dropped.
// RL15: a per-instruction count of outstanding operand bytes is kept.
`timescale 1ns/10ps
module rip_port (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_acc_valid,
    input  wire rip_pkg::rip_acc_s i_acc,
    output logic                   o_acc_ready,
    output logic [15:0]            o_acc_rdata,
    input  wire logic              i_flag_clear,
    output logic                   o_output_error_flag,
    output logic                   o_operand_error_flag,
    output logic                   o_core_valid,
    output rip_pkg::rip_link_s     o_core,
    input  wire logic              i_core_ready,
    input  wire logic              i_ret_valid,
    input  wire rip_pkg::rip_ret_s i_ret,
    output logic                   o_core_reset_strobe
);
    import rip_pkg::*;

    // operand length of an instruction byte: {endless, count}
    function automatic logic [2:0] instr_len(input logic [7:0] instr);
        logic [5:0] addr;
        addr = instr[5:0] & RIP_ADDR_MASK;
        if (instr[RIP_BURST_BIT]) begin
            instr_len = {1'b1, RIP_LEN_SINGLE};
        end else if (addr >= RIP_STROBE_LO && addr <= RIP_STROBE_HI) begin
            instr_len = {1'b0, RIP_LEN_STROBE};
        end else begin
            instr_len = {1'b0, RIP_LEN_SINGLE};
        end
    endfunction : instr_len

    rip_link_s  buf_q [RIP_BUF_DEPTH];
    rip_link_s  buf_d [RIP_BUF_DEPTH];
    logic       wr_ptr_q, wr_ptr_d;
    logic       rd_ptr_q, rd_ptr_d;
    logic [1:0] cnt_q, cnt_d;
    logic [7:0] dout_q [RIP_DOUT_DEPTH];
    logic [7:0] dout_d [RIP_DOUT_DEPTH];
    logic [1:0] dcnt_q, dcnt_d;
    logic [7:0] stat_q, stat_d;
    logic       word_last_q, word_last_d;
    logic [1:0] rem_q, rem_d;
    logic       endless_q, endless_d;
    logic [4:0] wait_q, wait_d;
    logic       out_err_q, out_err_d;
    logic       op_err_q, op_err_d;
    logic       rst_strobe_q, rst_strobe_d;

    rip_link_s  ent [2];
    logic [1:0] npush;
    logic [1:0] nneed;
    logic [1:0] npop_dout;
    logic       cond_ok;
    logic       byte_stat_w;
    logic       timeout;
    logic       done;
    logic       pop;
    logic       is_reset;
    logic [2:0] len;
    logic [1:0] n_ops;
    logic [1:0] allowed;
    logic [1:0] free;
    logic [1:0] dc;
    logic [7:0] dtmp [RIP_DOUT_DEPTH];

    assign o_core_valid         = (cnt_q != 2'h0);
    assign o_core               = buf_q[rd_ptr_q];
    assign o_output_error_flag  = out_err_q;
    assign o_operand_error_flag = op_err_q;
    assign o_core_reset_strobe  = rst_strobe_q;
    assign pop                  = o_core_valid && i_core_ready;
    assign free                 = 2'(RIP_BUF_DEPTH) - cnt_q;

    always_comb begin
        ent[0]       = '0;
        ent[1]       = '0;
        npush        = 2'h0;
        nneed        = 2'h0;
        npop_dout    = 2'h0;
        cond_ok      = 1'b1;
        byte_stat_w  = 1'b0;
        is_reset     = 1'b0;
        len          = 3'h0;
        n_ops        = 2'h0;
        allowed      = 2'h0;
        dc           = 2'h0;
        dtmp[0]      = dout_q[0];
        dtmp[1]      = dout_q[1];
        o_acc_rdata  = 16'h0000;
        wr_ptr_d     = wr_ptr_q;
        rd_ptr_d     = rd_ptr_q;
        cnt_d        = cnt_q;
        buf_d[0]     = buf_q[0];
        buf_d[1]     = buf_q[1];
        dout_d[0]    = dout_q[0];
        dout_d[1]    = dout_q[1];
        dcnt_d       = dcnt_q;
        stat_d       = stat_q;
        word_last_d  = word_last_q;
        rem_d        = rem_q;
        endless_d    = endless_q;
        out_err_d    = out_err_q && !i_flag_clear;
        op_err_d     = op_err_q && !i_flag_clear;
        rst_strobe_d = 1'b0;

        // room needed in the buffer, or data needed from the core
        case (i_acc.sel)
            RIP_INSTR_B: nneed = 2'h1;
            RIP_INSTR_W: nneed = 2'h2;
            RIP_DIN_B:   nneed = 2'h1;
            RIP_DIN_W:   nneed = 2'h2;
            RIP_DOUT_B:  cond_ok = (dcnt_q >= 2'h1);
            RIP_DOUT_W:  cond_ok = (dcnt_q >= 2'h2);
            RIP_STAT_W: begin
                byte_stat_w = !word_last_q;                        // see RL8
                cond_ok     = word_last_q && (dcnt_q >= 2'h1);
            end
            default:     cond_ok = 1'b1;
        endcase
        if (nneed != 2'h0) begin
            cond_ok = (free >= nneed);
        end
        // stall until resolved or the wait runs out
        timeout     = (wait_q == 5'(RIP_STALL_MAX - 1));           // see RL13
        done        = i_acc_valid && (cond_ok || timeout || byte_stat_w);
        o_acc_ready = done;
        wait_d      = (i_acc_valid && !done) ? wait_q + 5'h1 : 5'h0;

        // read data, taken in the same cycle as the ready
        case (i_acc.sel)
            RIP_STAT_B: o_acc_rdata = {8'h00, stat_q};             // see RL6
            RIP_STAT_W: o_acc_rdata = {stat_q, dout_q[0]};         // see RL7
            RIP_DOUT_B: o_acc_rdata = {8'h00, dout_q[0]};          // see RL3
            RIP_DOUT_W: o_acc_rdata = {dout_q[0], dout_q[1]};
            default:    o_acc_rdata = 16'h0000;
        endcase

        if (done) begin
            case (i_acc.sel)
                RIP_INSTR_B, RIP_INSTR_W: begin
                    if (cond_ok) begin
                        is_reset = (i_acc.sel == RIP_INSTR_B)
                                   ? (i_acc.wdata[7:0] == RIP_RESET_STROBE)
                                   : (i_acc.wdata[15:8] == RIP_RESET_STROBE);
                        // a pending finite instruction ends here
                        if (rem_q != 2'h0 && !endless_q) begin     // see RL11
                            op_err_d = 1'b1;                       // see RL12
                        end
                        if (i_acc.sel == RIP_INSTR_B) begin
                            ent[0] = '{is_instr: 1'b1, data: i_acc.wdata[7:0]};  // see RL5
                            len    = instr_len(i_acc.wdata[7:0]);
                            npush  = 2'h1;
                        end else begin
                            ent[0] = '{is_instr: 1'b1, data: i_acc.wdata[15:8]}; // see RL4
                            ent[1] = '{is_instr: 1'b0, data: i_acc.wdata[7:0]};
                            len    = instr_len(i_acc.wdata[15:8]);
                            npush  = 2'h2;
                        end
                        // the no-op strobe goes out like any strobe, only for its status
                        endless_d   = len[2];                      // see RL9
                        rem_d       = len[1:0];                    // see RL15
                        word_last_d = (i_acc.sel == RIP_INSTR_W);
                        if (i_acc.sel == RIP_INSTR_W && !len[2]) begin
                            if (len[1:0] == 2'h0) begin
                                npush    = 2'h1;                   // see RL14
                                op_err_d = 1'b1;
                            end else begin
                                rem_d = len[1:0] - 2'h1;
                            end
                        end
                    end else begin
                        op_err_d = 1'b1;                           // see RL13
                    end
                end
                RIP_DIN_B, RIP_DIN_W: begin
                    n_ops   = (i_acc.sel == RIP_DIN_W) ? 2'h2 : 2'h1;
                    allowed = (endless_q || rem_q >= n_ops) ? n_ops : rem_q;
                    if (!cond_ok) begin
                        allowed  = 2'h0;
                        op_err_d = 1'b1;                           // see RL13
                    end else if (allowed != n_ops) begin
                        op_err_d = 1'b1;                           // see RL14
                    end
                    if (!endless_q) begin
                        rem_d = rem_q - allowed;                   // see RL15
                    end
                    // words go out high byte first, as the core expects
                    if (n_ops == 2'h2) begin
                        ent[0] = '{is_instr: 1'b0, data: i_acc.wdata[15:8]};
                        ent[1] = '{is_instr: 1'b0, data: i_acc.wdata[7:0]};
                    end else begin
                        ent[0] = '{is_instr: 1'b0, data: i_acc.wdata[7:0]};
                    end
                    npush = allowed;                               // see RL2
                end
                RIP_DOUT_B, RIP_DOUT_W, RIP_STAT_W: begin
                    if (!cond_ok) begin
                        out_err_d = 1'b1;                          // see RL8
                    end
                    if (i_acc.sel == RIP_DOUT_W) begin
                        npop_dout = (dcnt_q >= 2'h2) ? 2'h2 : dcnt_q;
                    end else begin
                        npop_dout = (dcnt_q != 2'h0) ? 2'h1 : 2'h0;
                    end
                end
                default: npop_dout = 2'h0;
            endcase
        end

        // core returns: status refreshes, data lands in the output queue
        dc = dcnt_q - npop_dout;
        if (npop_dout == 2'h1) begin
            dtmp[0] = dout_q[1];
        end
        if (i_ret_valid) begin
            if (i_ret.is_status) begin
                stat_d = i_ret.data;                               // see RL1
            end else if (dc < 2'(RIP_DOUT_DEPTH)) begin
                dtmp[dc[0]] = i_ret.data;                          // see RL2
                dc          = dc + 2'h1;
            end else begin
                // a full queue keeps the newest byte; software read too little
                dtmp[0] = dtmp[1];
                dtmp[1] = i_ret.data;
            end
        end
        dout_d[0] = dtmp[0];
        dout_d[1] = dtmp[1];
        dcnt_d    = dc;

        // two-entry buffer towards the core
        for (int i = 0; i < 2; i++) begin
            if (2'(i) < npush) begin
                buf_d[1'(wr_ptr_q + 1'(i))] = ent[i];
            end
        end
        wr_ptr_d = wr_ptr_q + npush[0];
        rd_ptr_d = rd_ptr_q + pop;
        cnt_d    = cnt_q + npush - {1'b0, pop};

        // the reset strobe never reaches the buffer; instead it clears the port except the error flags
        if (is_reset) begin                                        // see RL10
            rst_strobe_d = 1'b1;
            wr_ptr_d     = 1'b0;
            rd_ptr_d     = 1'b0;
            cnt_d        = 2'h0;
            dcnt_d       = 2'h0;
            stat_d       = RIP_STAT_RESET;
            word_last_d  = 1'b0;
            rem_d        = 2'h0;
            endless_d    = 1'b0;
            op_err_d     = op_err_q && !i_flag_clear;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            buf_q[0]     <= '0;
            buf_q[1]     <= '0;
            wr_ptr_q     <= 1'b0;
            rd_ptr_q     <= 1'b0;
            cnt_q        <= 2'h0;
            dout_q[0]    <= RIP_DOUT_RESET;
            dout_q[1]    <= RIP_DOUT_RESET;
            dcnt_q       <= 2'h0;
            stat_q       <= RIP_STAT_RESET;
            word_last_q  <= 1'b0;
            rem_q        <= 2'h0;
            endless_q    <= 1'b0;
            wait_q       <= 5'h00;
            out_err_q    <= 1'b0;
            op_err_q     <= 1'b0;
            rst_strobe_q <= 1'b0;
        end else begin
            buf_q[0]     <= buf_d[0];
            buf_q[1]     <= buf_d[1];
            wr_ptr_q     <= wr_ptr_d;
            rd_ptr_q     <= rd_ptr_d;
            cnt_q        <= cnt_d;
            dout_q[0]    <= dout_d[0];
            dout_q[1]    <= dout_d[1];
            dcnt_q       <= dcnt_d;
            stat_q       <= stat_d;
            word_last_q  <= word_last_d;
            rem_q        <= rem_d;
            endless_q    <= endless_d;
            wait_q       <= wait_d;
            out_err_q    <= out_err_d;
            op_err_q     <= op_err_d;
            rst_strobe_q <= rst_strobe_d;
        end
    end

endmodule : rip_port

// *** tb/rip_core_model.sv ***
// behavioural radio core on the far side of the port's byte link
`timescale 1ns/10ps
module rip_core_model (
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    input  wire logic               i_stall,
    input  wire logic               i_core_valid,
    input  wire rip_pkg::rip_link_s i_core,
    input  wire logic               i_core_reset_strobe,
    output logic                    o_core_ready,
    output logic                    o_ret_valid,
    output rip_pkg::rip_ret_s       o_ret
);
    import rip_pkg::*;
    logic [7:0] cnt_q;
    assign o_core_ready = !i_stall;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= 8'h00;
            o_ret_valid <= 1'b0;
            o_ret <= '0;
        end else if (i_core_reset_strobe) begin
            cnt_q <= 8'h00;
            o_ret_valid <= 1'b0;
        end else if (i_core_valid && !i_stall) begin
            o_ret_valid <= 1'b1;
            o_ret.is_status <= i_core.is_instr;
            if (i_core.is_instr) begin
                cnt_q <= cnt_q + 8'h01;
                o_ret.data <= cnt_q + 8'h01;
            end else begin
                o_ret.data <= i_core.data ^ 8'ha5;
            end
        end else begin
            o_ret_valid <= 1'b0;
            // idle data keeps moving so a stale byte never looks valid
            o_ret.data <= ~o_ret.data;
        end
    end
endmodule : rip_core_model

// *** tb/rip_port_sva.sv ***
// concurrent checks on the radio instruction port
`timescale 1ns/10ps
module rip_port_sva (
    input wire logic               i_clk,
    input wire logic               i_reset,
    input wire logic               i_acc_valid,
    input wire rip_pkg::rip_acc_s  i_acc,
    input wire logic               o_acc_ready,
    input wire logic [15:0]        o_acc_rdata,
    input wire logic               i_flag_clear,
    input wire logic               o_output_error_flag,
    input wire logic               o_operand_error_flag,
    input wire logic               o_core_valid,
    input wire rip_pkg::rip_link_s o_core,
    input wire logic               i_core_ready,
    input wire logic               o_core_reset_strobe
);
    import rip_pkg::*;
    logic [4:0] wait_q, wait_d;
    logic       last_b_q, last_b_d, pend_q, pend_d;
    logic       done, instr_b, rst_acc, one_op;
    assign done    = i_acc_valid && o_acc_ready;
    assign instr_b = done && i_acc.sel == RIP_INSTR_B;
    assign rst_acc = instr_b && i_acc.wdata[7:0] == RIP_RESET_STROBE;
    assign one_op  = !i_acc.wdata[6] &&
                     (i_acc.wdata[5:0] < RIP_STROBE_LO || i_acc.wdata[5:0] > RIP_STROBE_HI);
    always_comb begin
        wait_d = (i_acc_valid && !o_acc_ready) ? wait_q + 5'h01 : 5'h00;
        last_b_d = last_b_q;
        pend_d = pend_q;
        if (done && i_acc.sel inside {RIP_INSTR_W, RIP_DIN_B, RIP_DIN_W}) pend_d = 1'b0;
        if (done && i_acc.sel == RIP_INSTR_W) last_b_d = 1'b0;
        if (instr_b) pend_d = one_op;
        if (instr_b && !rst_acc) last_b_d = 1'b1;
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_q <= 5'h00;
            last_b_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            last_b_q <= last_b_d;
            pend_q <= pend_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_statw_b;
        i_acc_valid && i_acc.sel == RIP_STAT_W && last_b_q;
    endsequence
    sequence s_word_instr;
        done && i_acc.sel == RIP_INSTR_W && !o_core_valid;
    endsequence
    AST_STALL_MAX: assert property (wait_q < 5'(RIP_STALL_MAX))
        else $error("access stalled too long");
    AST_STATW_NOW: assert property (s_statw_b |-> o_acc_ready)
        else $error("status word read after byte instruction stalled");
    AST_STATW_ERR: assert property (s_statw_b |=> o_output_error_flag)
        else $error("output error flag not set");
    AST_RST_PULSE: assert property (rst_acc |=> o_core_reset_strobe)
        else $error("core reset strobe missing");
    AST_RST_FLUSH: assert property (o_core_reset_strobe && !i_acc_valid |=> !o_core_valid)
        else $error("link buffer kept data over core reset");
    AST_ABORT: assert property (instr_b && !rst_acc && pend_q |=> o_operand_error_flag)
        else $error("aborted instruction left operand flag clear");
    AST_STICKY: assert property (o_operand_error_flag && !i_flag_clear |=> o_operand_error_flag)
        else $error("operand flag dropped without clear");
    AST_CLEAR: assert property (i_flag_clear && !i_acc_valid |=>
        !o_output_error_flag && !o_operand_error_flag)
        else $error("error flags not cleared");
    AST_CORE_HOLD: assert property (o_core_valid && !i_core_ready && !rst_acc && !o_core_reset_strobe
        |=> o_core_valid && $stable(o_core))
        else $error("link byte changed while stalled");
    AST_WORD_HEAD: assert property (s_word_instr |=>
        o_core.is_instr && o_core.data == $past(i_acc.wdata[15:8]))
        else $error("word instruction byte order wrong");
    AST_WRITE_ZERO: assert property (done && !i_acc.sel[2] |-> o_acc_rdata == 16'h0000)
        else $error("write returned nonzero data");
    AST_STATB_HI: assert property (done && i_acc.sel == RIP_STAT_B |-> o_acc_rdata[15:8] == 8'h00)
        else $error("byte status upper half nonzero");
endmodule : rip_port_sva
bind rip_port rip_port_sva u_rip_port_sva (.i_clk(i_clk), .i_reset(i_reset),
    .i_acc_valid(i_acc_valid), .i_acc(i_acc), .o_acc_ready(o_acc_ready),
    .o_acc_rdata(o_acc_rdata), .i_flag_clear(i_flag_clear),
    .o_output_error_flag(o_output_error_flag), .o_operand_error_flag(o_operand_error_flag),
    .o_core_valid(o_core_valid), .o_core(o_core), .i_core_ready(i_core_ready),
    .o_core_reset_strobe(o_core_reset_strobe));

// *** tb/rip_port_tb.sv ***
// self-checking bench for the radio instruction port
`timescale 1ns/10ps
module rip_port_tb;
    import rip_pkg::*;
    localparam logic [16:0] NC = 17'h00000;
    localparam logic [16:0] W0 = 17'h10000;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_acc_valid = 1'b0;
    rip_acc_s    i_acc = '0;
    logic        i_flag_clear = 1'b0;
    logic        stall = 1'b0;
    logic        hold = 1'b0;
    logic        o_acc_ready, o_output_error_flag, o_operand_error_flag;
    logic [15:0] o_acc_rdata;
    logic        o_core_valid, i_core_ready, i_ret_valid, o_core_reset_strobe;
    rip_link_s   o_core;
    rip_ret_s    i_ret;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic [7:0]  r;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          waits;
    integer      seed = 32'hdb1a;

    always #10 i_clk = ~i_clk;
    always @(negedge i_clk) stall <= hold | (($random(seed) & 3) == 0);

    rip_port u_rip_port (.i_clk(i_clk), .i_reset(i_reset), .i_acc_valid(i_acc_valid),
        .i_acc(i_acc), .o_acc_ready(o_acc_ready), .o_acc_rdata(o_acc_rdata),
        .i_flag_clear(i_flag_clear), .o_output_error_flag(o_output_error_flag),
        .o_operand_error_flag(o_operand_error_flag), .o_core_valid(o_core_valid),
        .o_core(o_core), .i_core_ready(i_core_ready), .i_ret_valid(i_ret_valid),
        .i_ret(i_ret), .o_core_reset_strobe(o_core_reset_strobe));
    rip_core_model u_rip_core_model (.i_clk(i_clk), .i_reset(i_reset), .i_stall(stall),
        .i_core_valid(o_core_valid), .i_core(o_core), .i_core_reset_strobe(o_core_reset_strobe),
        .o_core_ready(i_core_ready), .o_ret_valid(i_ret_valid), .o_ret(i_ret));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // request held from a falling edge until ready is seen at a rising edge
    task automatic acc(input rip_sel_e sel, input logic [15:0] wd, input logic [16:0] ex);
        @(negedge i_clk);
        exp_q.push_back(ex);
        i_acc_valid = 1'b1;
        i_acc = '{sel: sel, wdata: wd};
        waits = 0;
        do begin
            @(posedge i_clk);
            waits++;
        end while (o_acc_ready !== 1'b1 && waits < 40);
        // a hung access counts as a failure and drops its note
        if (o_acc_ready !== 1'b1) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            void'(exp_q.pop_front());
        end
    endtask : acc

    task automatic idle(input int n);
        @(negedge i_clk);
        i_acc_valid = 1'b0;
        repeat (n) @(negedge i_clk);
    endtask : idle

    task automatic flags(input logic oe, input logic pe);
        idle(2);
        check({14'h0, o_output_error_flag, o_operand_error_flag}, {14'h0, oe, pe});
        i_flag_clear = 1'b1;
        @(negedge i_clk);
        i_flag_clear = 1'b0;
    endtask : flags

    task automatic fin(input string s);
        idle(2);
        $display("test %s finished", s);
    endtask : fin

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // every completed access answers the oldest queued note
    always @(posedge i_clk) begin
        if (i_acc_valid === 1'b1 && o_acc_ready === 1'b1) begin
            e = exp_q.pop_front();
            if (e[16]) check(o_acc_rdata, e[15:0]);
        end
    end

    initial begin
        #100000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        acc(RIP_STAT_B, 16'h0, {9'h100, RIP_STAT_RESET});
        fin("reset");
        acc(RIP_INSTR_W, 16'h0511, W0);
        idle(10);
        acc(RIP_STAT_W, 16'h0, {9'h101, 8'h11 ^ 8'ha5});
        fin("word instruction");
        acc(RIP_INSTR_B, 16'h0005, W0);
        acc(RIP_DIN_B, 16'h0022, W0);
        acc(RIP_DOUT_B, 16'h0, {9'h100, 8'h22 ^ 8'ha5});
        idle(10);
        acc(RIP_STAT_B, 16'h0, 17'h10002);
        acc(RIP_STAT_W, 16'h0, NC);
        flags(1'b1, 1'b0);
        fin("byte instruction");
        acc(RIP_INSTR_B, 16'h003d, W0);
        idle(10);
        acc(RIP_STAT_B, 16'h0, 17'h10003);
        acc(RIP_DOUT_W, 16'h0, NC);
        check(16'(waits), 16'(RIP_STALL_MAX));
        flags(1'b1, 1'b0);
        fin("no-op and stalled read");
        acc(RIP_INSTR_B, 16'h0005, W0);
        acc(RIP_INSTR_B, 16'h003d, W0);
        idle(10);
        acc(RIP_STAT_B, 16'h0, 17'h10005);
        flags(1'b0, 1'b1);
        fin("abort");
        acc(RIP_INSTR_W, 16'h3d00, W0);
        idle(10);
        acc(RIP_INSTR_B, 16'h0030, W0);
        idle(10);
        acc(RIP_STAT_B, 16'h0, {9'h100, RIP_STAT_RESET});
        flags(1'b0, 1'b1);
        fin("surplus operand and core reset");
        hold = 1'b1;
        fork
            begin
                repeat (6) @(negedge i_clk);
                hold = 1'b0;
            end
        join_none
        repeat (12) begin
            r = 8'($random(seed));
            acc(RIP_INSTR_W, {8'h05, r}, W0);
            acc(RIP_DOUT_B, 16'h0, {9'h100, r ^ 8'ha5});
        end
        idle(10);
        acc(RIP_STAT_B, 16'h0, 17'h1000c);
        fin("random traffic");
        // endless instruction takes a whole word; a single-operand one drops the surplus
        acc(RIP_INSTR_B, 16'h0045, W0);
        acc(RIP_DIN_W, 16'h1234, W0);
        acc(RIP_DOUT_W, 16'h0, {1'b1, 8'h12 ^ 8'ha5, 8'h34 ^ 8'ha5});
        acc(RIP_INSTR_B, 16'h0005, W0);
        acc(RIP_DIN_W, 16'h5678, W0);
        acc(RIP_DOUT_B, 16'h0, {9'h100, 8'h56 ^ 8'ha5});
        flags(1'b0, 1'b1);
        fin("operand count");
        end_sim();
    end
endmodule : rip_port_tb
